// ==== src/reload_timer_map.svh ====
/*
  Register offsets, source codes, reset values and timing counts
  for the reload timer with period capture.
  Assumes a 32-bit APB slave with byte addresses on paddr[7:0].
*/
`ifndef RELOAD_TIMER_MAP_SVH
`define RELOAD_TIMER_MAP_SVH

`define ADDR_CONTROL      8'h00
`define ADDR_CLOCK_CTRL   8'h04
`define ADDR_LOW_COUNT    8'h08
`define ADDR_HIGH_COUNT   8'h0C
`define ADDR_LOW_RELOAD   8'h10
`define ADDR_HIGH_RELOAD  8'h14

`define CONTROL_RESET     8'h00
`define CLOCK_CTRL_RESET  3'h0
`define BYTE_RESET        8'h00
`define BYTE_MAX          8'hFF

`define EXT_SYS_DIV12     2'h0
`define EXT_RTC_DIV8      2'h1
`define EXT_RESERVED      2'h2
`define EXT_COMPARATOR    2'h3

`define SYS_DIVIDE        4'hC
`define RTC_DIVIDE        3'h7

`endif

// ==== src/reload_timer_pkg.sv ====
/*
  Types shared by the reload timer files.
  Assumes the constants header is compiled alongside.
*/
package reload_timer_pkg;

  typedef struct packed {
    logic       high_flag;
    logic       low_flag;
    logic       low_irq_en;
    logic       capture_en;
    logic       split;
    logic       run;
    logic [1:0] ext_sel;
  } control_t;

  typedef struct packed {
    logic irq_en;
    logic high_sys;
    logic low_sys;
  } clock_ctrl_t;

  typedef struct packed {
    logic div12;
    logic rtc_div8;
    logic comp_rise;
  } ticks_t;

endpackage

// ==== src/clock_source_select.sv ====
/*
  Count pulse selection for one half of the timer.
  Assumes all tick inputs are single-cycle pulses on pclk.
*/
`include "reload_timer_map.svh"

module clock_source_select
  import reload_timer_pkg::*;
(
  input  wire logic       sys_select, // Count every pclk when high
  input  wire logic [1:0] ext_select, // External source code
  input  wire ticks_t     ticks,      // Slow source pulses
  output logic            tick        // Count pulse for this half
);

  always_comb begin
    tick = 1'b0;
    if (sys_select) begin
      tick = 1'b1;
    end else begin
      case (ext_select)
        `EXT_SYS_DIV12:  tick = ticks.div12;
        `EXT_RTC_DIV8:   tick = ticks.rtc_div8;
        `EXT_COMPARATOR: tick = ticks.comp_rise;
        default:         tick = 1'b0;
      endcase
    end
  end

endmodule // clock_source_select

// ==== src/reload_timer.sv ====
/*
  Reload timer with period capture, programmed over APB.
  Assumes comparator_in and rtc_clk_in are asynchronous levels that
  change much slower than pclk.
*/
// Decided for this implementation: the APB register port and the address map.
`include "reload_timer_map.svh"

module reload_timer (
  input  wire logic        pclk,          // System clock, 25 MHz
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB write
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  input  wire logic        comparator_in, // Comparator output level
  input  wire logic        rtc_clk_in,    // Real-time clock level
  output logic [31:0]      prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error, unmapped
  output logic             timer_irq      // Timer interrupt request
);
  import reload_timer_pkg::*;

  // Software-visible state.
  control_t    ctrl;
  control_t    next_ctrl;
  clock_ctrl_t clk_ctrl;
  clock_ctrl_t next_clk_ctrl;
  logic [7:0]  low_count_byte;
  logic [7:0]  next_low_count_byte;
  logic [7:0]  high_count_byte;
  logic [7:0]  next_high_count_byte;
  logic [7:0]  low_reload_byte;
  logic [7:0]  next_low_reload_byte;
  logic [7:0]  high_reload_byte;
  logic [7:0]  next_high_reload_byte;

  logic [1:0]  comp_sync;
  logic [1:0]  next_comp_sync;
  logic [1:0]  rtc_sync;
  logic [1:0]  next_rtc_sync;
  logic        comp_last;
  logic        next_comp_last;
  logic        rtc_last;
  logic        next_rtc_last;
  logic [3:0]  sys_div;
  logic [3:0]  next_sys_div;
  logic [2:0]  rtc_div;
  logic [2:0]  next_rtc_div;
  // Pulses from the slow sources, one pclk wide.
  ticks_t      ticks;

  // Next values of the registered bus answer and interrupt.
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_timer_irq;

  // Per-cycle decode of the timer core and the APB port; none of these is stored.
  logic        low_tick;
  logic        high_tick;
  logic        low_inc;
  logic        high_inc;
  logic        low_wrap;
  logic        full_wrap;
  logic        capture;
  logic        set_high_flag;
  logic        set_low_flag;
  logic        setup;
  logic        wr_access;
  logic        mapped;
  logic [31:0] read_word;

  // Synchroniser group. Only the second stage of each pair feeds logic;
  // the first stage may still be settling when pclk samples it.
  always_comb begin
    next_comp_sync = {comp_sync[0], comparator_in};
    next_rtc_sync  = {rtc_sync[0], rtc_clk_in};
    next_comp_last = comp_sync[1];
    next_rtc_last  = rtc_sync[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_sync <= 2'h0;
      rtc_sync  <= 2'h0;
      comp_last <= 1'b0;
      rtc_last  <= 1'b0;
    end else begin
      comp_sync <= next_comp_sync;
      rtc_sync  <= next_rtc_sync;
      comp_last <= next_comp_last;
      rtc_last  <= next_rtc_last;
    end
  end

  // Divider group. The divide-by-12 runs free from reset, so its first
  // pulse after a mode change may come early; a user who needs an exact
  // first interval must start from the system clock instead.
  // The oscillator divider counts synchronised rising edges, so each
  // rising oscillator edge is seen exactly once however it falls against pclk.
  always_comb begin
    ticks.comp_rise = comp_sync[1] & ~comp_last;
    ticks.div12    = (sys_div == `SYS_DIVIDE - 4'h1);
    next_sys_div   = ticks.div12 ? 4'h0 : sys_div + 4'h1;
    next_rtc_div   = rtc_div;
    ticks.rtc_div8 = 1'b0;
    if (rtc_sync[1] & ~rtc_last) begin
      next_rtc_div   = rtc_div + 3'h1;
      ticks.rtc_div8 = (rtc_div == `RTC_DIVIDE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div <= 4'h0;
      rtc_div <= 3'h0;
    end else begin
      sys_div <= next_sys_div;
      rtc_div <= next_rtc_div;
    end
  end

  // Both halves share the source code; only the select bits differ,
  // which is why each half has its own selector.
  clock_source_select low_source (
    .sys_select (clk_ctrl.low_sys),
    .ext_select (ctrl.ext_sel),
    .ticks      (ticks),
    .tick       (low_tick)
  );

  clock_source_select high_source (
    .sys_select (clk_ctrl.high_sys),
    .ext_select (ctrl.ext_sel),
    .ticks      (ticks),
    .tick       (high_tick)
  );

  // APB decode. Every transfer takes exactly one access cycle.
  // Writes to an unmapped address fall through the decode and change
  // nothing; the error answer is the only trace they leave.
  always_comb begin
    setup     = psel & ~penable;
    wr_access = psel & penable & pready & pwrite;
    mapped    = 1'b1;
    read_word = 32'h0000_0000;
    case (paddr)
      `ADDR_CONTROL:     read_word = {24'h00_0000, ctrl};
      `ADDR_CLOCK_CTRL:  read_word = {29'h0000_0000, clk_ctrl};
      `ADDR_LOW_COUNT:   read_word = {24'h00_0000, low_count_byte};
      `ADDR_HIGH_COUNT:  read_word = {24'h00_0000, high_count_byte};
      `ADDR_LOW_RELOAD:  read_word = {24'h00_0000, low_reload_byte};
      `ADDR_HIGH_RELOAD: read_word = {24'h00_0000, high_reload_byte};
      default:           mapped = 1'b0;
    endcase
    next_pready  = setup;
    next_pslverr = setup & ~mapped;
    next_prdata  = (setup & ~pwrite) ? read_word : 32'h0000_0000;
  end

  // Timer core. Software writes to data bytes win over counting in the
  // same cycle, but a flag that hardware sets in that cycle stays set.
  always_comb begin
    next_ctrl             = ctrl;
    next_clk_ctrl         = clk_ctrl;
    next_low_count_byte   = low_count_byte;
    next_high_count_byte  = high_count_byte;
    next_low_reload_byte  = low_reload_byte;
    next_high_reload_byte = high_reload_byte;
    set_high_flag         = 1'b0;
    set_low_flag          = 1'b0;

    // In 16-bit mode the low half's source drives the whole counter.
    low_inc   = ctrl.split ? low_tick : (low_tick & ctrl.run);
    high_inc  = ctrl.split & high_tick & ctrl.run;
    low_wrap  = low_inc & (low_count_byte == `BYTE_MAX);
    full_wrap = low_wrap & (high_count_byte == `BYTE_MAX);
    // The upper source bit picks the capture event in capture mode.
    capture   = ctrl.capture_en &
                (ctrl.ext_sel[1] ? ticks.comp_rise
                                 : ticks.rtc_div8);

    if (low_inc) begin
      next_low_count_byte = low_count_byte + 8'h01;
    end
    if (low_wrap) begin
      set_low_flag = 1'b1;
    end

    // 16-bit mode: the high byte steps on each low wrap, and the pair
    // reloads only when both bytes wrap together.
    if (!ctrl.split) begin
      if (low_wrap) begin
        next_high_count_byte = high_count_byte + 8'h01;
      end
      if (full_wrap) begin
        set_high_flag = 1'b1;
        // Capture owns the reload pair, so the counter free-runs there.
        if (!ctrl.capture_en) begin
          next_low_count_byte  = low_reload_byte;
          next_high_count_byte = high_reload_byte;
        end
      end
    end else begin
      // Each byte reloads on its own wrap; the low byte ignores run so
      // that it can pace a second, free-running event.
      if (low_wrap) begin
        next_low_count_byte = low_reload_byte;
      end
      if (high_inc) begin
        if (high_count_byte == `BYTE_MAX) begin
          next_high_count_byte = high_reload_byte;
          set_high_flag        = 1'b1;
        end else begin
          next_high_count_byte = high_count_byte + 8'h01;
        end
      end
    end

    // A capture overwrites the reload pair; software must read it before
    // the next event or the earlier period is lost.
    if (capture) begin
      next_low_reload_byte  = low_count_byte;
      next_high_reload_byte = high_count_byte;
      set_high_flag         = 1'b1;
    end

    // Software writes come last so that they override counting, and the
    // flags are merged after them so that a hardware set is never lost.
    if (wr_access) begin
      case (paddr)
        `ADDR_CONTROL:     next_ctrl = control_t'(pwdata[7:0]);
        `ADDR_CLOCK_CTRL:  next_clk_ctrl = clock_ctrl_t'(pwdata[2:0]);
        `ADDR_LOW_COUNT:   next_low_count_byte = pwdata[7:0];
        `ADDR_HIGH_COUNT:  next_high_count_byte = pwdata[7:0];
        `ADDR_LOW_RELOAD:  next_low_reload_byte = pwdata[7:0];
        `ADDR_HIGH_RELOAD: next_high_reload_byte = pwdata[7:0];
        default:           next_ctrl = ctrl;
      endcase
    end

    // Flags fall only by a software write; a set in the same cycle wins.
    next_ctrl.high_flag = next_ctrl.high_flag | set_high_flag;
    next_ctrl.low_flag  = next_ctrl.low_flag | set_low_flag;
  end

  // Interrupt group. The request is a level taken from the registered
  // flags, so it rises one cycle after a flag and stays up until
  // software clears that flag or its enable. With both enables set the handler must
  // inspect both flags to find the cause.
  always_comb begin
    next_timer_irq = 1'b0;
    if (clk_ctrl.irq_en) begin
      next_timer_irq = ctrl.high_flag;
      if (ctrl.low_irq_en & ctrl.low_flag) begin
        next_timer_irq = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= next_timer_irq;
    end
  end

  // Bus group. The answer is launched from the setup cycle, so it leaves
  // a flip-flop and still needs no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Timer group. Reset leaves the timer stopped in 16-bit mode with
  // every byte and flag at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl             <= control_t'(`CONTROL_RESET);
      clk_ctrl         <= clock_ctrl_t'(`CLOCK_CTRL_RESET);
      low_count_byte   <= `BYTE_RESET;
      high_count_byte  <= `BYTE_RESET;
      low_reload_byte  <= `BYTE_RESET;
      high_reload_byte <= `BYTE_RESET;
    end else begin
      ctrl             <= next_ctrl;
      clk_ctrl         <= next_clk_ctrl;
      low_count_byte   <= next_low_count_byte;
      high_count_byte  <= next_high_count_byte;
      low_reload_byte  <= next_low_reload_byte;
      high_reload_byte <= next_high_reload_byte;
    end
  end

endmodule // reload_timer

// ==== dv/reload_timer_assertions.sv ====
/* Port checker for the reload timer.
   Assumes it is bound to reload_timer and sees only its ports. */
`include "reload_timer_map.svh"
module reload_timer_assertions (
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset
  input wire logic        psel,          // Select
  input wire logic        penable,       // Access
  input wire logic        pwrite,        // Write
  input wire logic [7:0]  paddr,         // Address
  input wire logic [31:0] pwdata,        // Write data
  input wire logic        comparator_in, // Comparator
  input wire logic        rtc_clk_in,    // Oscillator
  input wire logic [31:0] prdata,        // Read data
  input wire logic        pready,        // Ready
  input wire logic        pslverr,       // Error
  input wire logic        timer_irq      // Interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, wr, rd_ctrl, mapped, irq_en_q, high_seen, low_seen;
  assign acc     = psel && penable && pready;
  assign wr      = acc && pwrite;
  assign rd_ctrl = acc && !pwrite && paddr == `ADDR_CONTROL;
  assign mapped  = paddr <= `ADDR_HIGH_RELOAD && paddr[1:0] == 2'h0;
  // Flags are judged only after software has seen them set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q  <= 1'h0;
      high_seen <= 1'h0;
      low_seen  <= 1'h0;
    end else begin
      if (wr && paddr == `ADDR_CLOCK_CTRL) irq_en_q <= pwdata[2];
      if (wr && paddr == `ADDR_CONTROL) begin
        high_seen <= 1'h0;
        low_seen  <= 1'h0;
      end else if (rd_ctrl) begin
        high_seen <= high_seen | prdata[7];
        low_seen  <= low_seen | prdata[6];
      end
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_bus_quiet: assert property (!pready |-> prdata == 0 && !pslverr)
    else $error("read bus not quiet");
  a_unmapped_err: assert property (s_access ##0 !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (s_access ##0 mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_irq_masked: assert property (
    !irq_en_q && !$past(irq_en_q) |-> !timer_irq)
    else $error("interrupt while disabled");
  a_high_sticky: assert property (rd_ctrl && high_seen |-> prdata[7])
    else $error("high flag cleared by hardware");
  a_low_sticky: assert property (rd_ctrl && low_seen |-> prdata[6])
    else $error("low flag cleared by hardware");
  a_irq_holds: assert property (
    timer_irq && !wr && !$past(wr) |=> timer_irq)
    else $error("interrupt dropped without a write");
endmodule // reload_timer_assertions

bind reload_timer reload_timer_assertions reload_timer_assertions_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .comparator_in, .rtc_clk_in, .prdata, .pready, .pslverr, .timer_irq);

// ==== dv/timer_pins_model.sv ====
/* Model of the comparator output and the real-time clock oscillator.
   Assumes a 40 ns pclk; both levels run free, unrelated in phase. */
module timer_pins_model (
  output logic comparator_in, // Comparator level, 16 pclk period
  output logic rtc_clk_in     // Oscillator level, 10 pclk period
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both periods span many pclk so a captured period resolves well.
  initial begin
    rtc_clk_in = 1'h0;
    #13;
    forever #200 rtc_clk_in = ~rtc_clk_in;
  end
  initial begin
    comparator_in = 1'h0;
    #27;
    forever #320 comparator_in = ~comparator_in;
  end
endmodule // timer_pins_model

// ==== dv/reload_timer_test.sv ====
/* Self-checking bench for the reload timer over APB.
   Assumes design, checker and pin model are compiled first. */
module reload_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import reload_timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        comparator_in, rtc_clk_in, timer_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        q_err;
  int          n_errors, comparisons;
  always #20 pclk = ~pclk;
  reload_timer reload_timer_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .comparator_in, .rtc_clk_in, .prdata,
    .pready, .pslverr, .timer_irq);
  timer_pins_model timer_pins_model_inst (.comparator_in, .rtc_clk_in);
  task automatic chk(input logic [31:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(pready, 1'h1, "no pready");
    q       = prdata;
    q_err   = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && timer_irq !== 1'h1; i++) @(posedge pclk);
  endtask
  task automatic t_reset_map;
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4));
      chk(q, 32'h0, "reset value");
    end
    rd(8'h18);
    chk(q, 32'h0, "unmapped read data");
    chk(q_err, 1'h1, "unmapped read error");
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10);
    chk(q, 32'hFF, "byte register width");
  endtask
  task automatic t_wrap16;
    wr(8'h04, 8'h05);
    wr(8'h10, 8'h34);
    wr(8'h14, 8'h12);
    wr(8'h08, 8'hF0);
    wr(8'h0C, 8'hFF);
    wr(8'h00, 8'h04);
    wait_irq(40);
    chk(timer_irq, 1'h1, "no overflow interrupt");
    rd(8'h00);
    chk(q[7:6], 2'h3, "overflow flags");
    rd(8'h0C);
    chk(q, 8'h12, "reload not loaded");
    rd(8'h00);
    chk(q[7], 1'h1, "high flag lost");
    wr(8'h00, 8'h00);
    repeat (2) @(posedge pclk);
    chk(timer_irq, 1'h0, "interrupt after clear");
  endtask
  task automatic t_low_irq;
    wr(8'h08, 8'hF0);
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h04);
    repeat (30) @(posedge pclk);
    chk(timer_irq, 1'h0, "low wrap interrupt unmasked");
    rd(8'h00);
    chk(q[7:6], 2'h1, "low flag only");
    wr(8'h00, 8'h64);
    wait_irq(4);
    chk(timer_irq, 1'h1, "no low wrap interrupt");
    wr(8'h00, 8'h00);
  endtask
  task automatic t_split;
    wr(8'h04, 8'h07);
    wr(8'h08, 8'hFE);
    wr(8'h0C, 8'hFE);
    wr(8'h10, 8'h80);
    wr(8'h14, 8'h40);
    wr(8'h00, 8'h08);
    repeat (4) @(posedge pclk);
    rd(8'h08);
    chk(q[7:4], 4'h8, "low byte reload");
    rd(8'h0C);
    chk(q, 8'hFE, "high byte ran without run");
    rd(8'h00);
    chk(q[7:6], 2'h1, "split flags");
    chk(timer_irq, 1'h0, "low interrupt not masked");
    wr(8'h00, 8'h0C);
    wait_irq(10);
    chk(timer_irq, 1'h1, "no high byte interrupt");
    rd(8'h0C);
    chk(q[7:4], 4'h4, "high byte reload");
    wr(8'h00, 8'h00);
  endtask
  task automatic t_sources;
    // Expected pulses in 480 cycles: /12, rtc /8 of 10, none, 16.
    int rate [4] = '{480 / 12, 480 / 80, 0, 480 / 16};
    int tol;
    wr(8'h04, 8'h00);
    for (int c = 0; c < 4; c++) begin
      tol = (c == 2) ? 0 : 1;
      wr(8'h08, 8'h00);
      wr(8'h0C, 8'h00);
      wr(8'h00, 8'(4 + c));
      repeat (480) @(posedge pclk);
      wr(8'h00, 8'(c));
      rd(8'h08);
      chk(q + tol >= rate[c] && q <= rate[c] + tol, 1, "rate");
    end
  endtask
  task automatic t_capture;
    // The rtc gives a capture every 8 x 10 pclk, the comparator 16.
    // Run is set as well, since a stopped counter captures one value.
    int         span [2] = '{8 * 10, 16};
    logic [7:0] first;
    wr(8'h04, 8'h05);
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, 8'(20 + 2 * s));
      for (int k = 0; k < 3; k++) begin
        repeat (2) @(posedge pclk);
        wait_irq(200);
        chk(timer_irq, 1'h1, "no capture interrupt");
        rd(8'h10);
        if (k == 2) chk(8'(q[7:0] - first), span[s], "period");
        first = q[7:0];
        wr(8'h00, 8'(20 + 2 * s));
      end
    end
    wr(8'h00, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    pclk    = 1'h0;
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset_map;
    t_wrap16;
    t_low_irq;
    t_split;
    t_sources;
    t_capture;
    tally_and_finish;
  end
  initial begin
    #(40 * 20000);
    n_errors++;
    tally_and_finish;
  end
endmodule // reload_timer_test
